// File: hw/flash_cfg_pkg.sv
package flash_cfg_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int CFG_W = 8;
  localparam int CFG_CODE_LSB = 12;
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h2aa;
  localparam logic [7:0] UNLOCK1_DATA = 8'haa;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_CONFIG = 8'hc0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  // Field positions inside the configuration code (code bit 0 is address bit 12)
  localparam int CFG_ASYNC_BIT = 7;
  localparam int CFG_RDY_BIT = 6;
  localparam int CFG_EDGE_BIT = 5;
  localparam int CFG_MODE_HI = 4;
  localparam int CFG_MODE_LO = 3;
  localparam int CFG_WAIT_HI = 2;
  localparam int CFG_WAIT_LO = 0;
  // Async, ready with data, rising edge, continuous, seven wait states
  localparam logic [7:0] CFG_RESET = 8'he5;
  localparam logic [1:0] MODE_CONT = 2'h0;
  localparam logic [1:0] MODE_WRAP8 = 2'h1;
  localparam logic [1:0] MODE_WRAP16 = 2'h2;
  localparam logic [1:0] MODE_WRAP32 = 2'h3;
  localparam logic [2:0] WAIT_FASTEST = 3'h0;
  localparam logic [3:0] WAIT_BASE = 4'h2;
  localparam logic [3:0] SLOW_START_EXTRA = 4'h2;
  localparam logic [5:0] SLOW_START_ADDR = 6'h3e;
  localparam int NUM_BANKS = 4;
  localparam logic [21:0] BANK_B_START = 22'h080000;
  localparam logic [21:0] BANK_C_START = 22'h200000;
  localparam logic [21:0] BANK_D_START = 22'h380000;
  localparam logic [7:0] ID_MFR_OFS = 8'h00;
  localparam logic [7:0] ID_DEV1_OFS = 8'h01;
  localparam logic [7:0] ID_DEV2_OFS = 8'h0e;
  localparam logic [7:0] ID_DEV3_OFS = 8'h0f;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {B_IDLE, B_WAIT, B_RUN} burst_state_t;
endpackage

// File: hw/word_fifo.sv
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t s_r;
  fifo_st_t s_nxt;
  logic push;
  logic pop;

  assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + AW'(1);
    end
    if (pop)
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + AW'(1);
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush)
    begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk)
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
endmodule

// File: hw/burst_addr_gen.sv
`timescale 1ns/100ps
module burst_addr_gen #(
  parameter int ADDR_W = 22
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [ADDR_W-1:0] start,
  input wire logic step,
  input wire logic [1:0] wrap_sel,
  output logic [ADDR_W-1:0] cur_addr
);
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } addr_st_t;

  addr_st_t s_r;
  addr_st_t s_nxt;
  logic [ADDR_W-1:0] mask;
  logic [ADDR_W-1:0] inc;

  assign cur_addr = s_r.addr;

  always_comb
  begin
    s_nxt = s_r;
    unique case (wrap_sel)
      flash_cfg_pkg::MODE_WRAP8: mask = ADDR_W'(7);
      flash_cfg_pkg::MODE_WRAP16: mask = ADDR_W'(15);
      flash_cfg_pkg::MODE_WRAP32: mask = ADDR_W'(31);
      default: mask = '1;
    endcase
    inc = s_r.addr + ADDR_W'(1);
    if (load)
      s_nxt.addr = start;
    else if (step)
      // Wrap inside the aligned block; whole-device wrap comes free from overflow
      s_nxt.addr = (s_r.addr & ~mask) | (inc & mask);
  end

  always_ff @(posedge ref_clk)
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
endmodule

// File: hw/flash_burst_config_and_mode_commands.sv
`timescale 1ns/100ps
module flash_burst_config_and_mode_commands #(
  parameter bit REDUCED_HS = 1'b1,
  parameter int FIFO_DEPTH = flash_cfg_pkg::FIFO_DEPTH,
  // Identification words: arbitrary neutral values
  parameter logic [15:0] ID_MFR = 16'h0011,
  parameter logic [15:0] ID_DEV1 = 16'h2233,
  parameter logic [15:0] ID_DEV2 = 16'h4455,
  parameter logic [15:0] ID_DEV3 = 16'h6677
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic address_valid_strobe_n,
  input wire logic burst_clk,
  input wire logic [21:0] addr,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe_n,
  output logic rdy_o,
  output logic rdy_oe_n,
  input wire logic [3:0] bank_busy,
  input wire logic lock_busy,
  input wire logic [3:0] time_limit_exceeded_bit,
  output logic [3:0] op_abort,
  output logic [3:0] bank_autosel,
  output logic [7:0] burst_configuration,
  output logic burst_config_set,
  output logic [21:0] arr_addr,
  output logic arr_req,
  input wire logic [15:0] arr_data,
  input wire logic arr_valid
);
  typedef struct packed {
    logic [1:0] ce_s;
    logic [1:0] oe_s;
    logic [2:0] we_s;
    logic [2:0] avd_s;
    logic [2:0] clk_s;
    logic [21:0] a1;
    logic [21:0] a2;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [1:0] cyc;
    logic [7:0] cfg;
    logic cfg_set;
    logic [3:0] autosel;
    logic [3:0] abort;
    flash_cfg_pkg::burst_state_t bst;
    logic [3:0] wait_cnt;
    logic as_read;
    logic fetch_on;
    logic flush;
    logic [15:0] dq;
    logic dq_oe_n;
    logic rdy;
    logic rdy_oe_n;
    logic req;
  } st_t;

  st_t s_r;
  st_t s_nxt;
  logic [21:0] cur_addr;
  logic ld;
  logic step;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [15:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [15:0] fifo_out_data;

  function automatic logic [1:0] bank_of(input logic [21:0] a);
    if (a >= flash_cfg_pkg::BANK_D_START)
      return 2'h3;
    else if (a >= flash_cfg_pkg::BANK_C_START)
      return 2'h2;
    else if (a >= flash_cfg_pkg::BANK_B_START)
      return 2'h1;
    else
      return 2'h0;
  endfunction

  function automatic logic [15:0] id_word(input logic [7:0] ofs);
    unique case (ofs)
      flash_cfg_pkg::ID_MFR_OFS: return ID_MFR;
      flash_cfg_pkg::ID_DEV1_OFS: return ID_DEV1;
      flash_cfg_pkg::ID_DEV2_OFS: return ID_DEV2;
      flash_cfg_pkg::ID_DEV3_OFS: return ID_DEV3;
      default: return 16'h0000;
    endcase
  endfunction

  assign dq_o = s_r.dq;
  assign dq_oe_n = s_r.dq_oe_n;
  assign rdy_o = s_r.rdy;
  assign rdy_oe_n = s_r.rdy_oe_n;
  assign op_abort = s_r.abort;
  assign bank_autosel = s_r.autosel;
  assign burst_configuration = s_r.cfg;
  assign burst_config_set = s_r.cfg_set;
  assign arr_addr = cur_addr;
  assign arr_req = s_r.req;

  logic wr_stb;
  logic avd_fall;
  logic act_edge;
  logic sync_mode;
  logic take;
  logic rdy_with_data;
  logic rise;
  logic fall;
  logic [1:0] bk;
  logic [3:0] init_cycles;
  logic [7:0] cmd;
  logic fill_ok;

  // Burst clock edges, seen two cycles late through the sampler
  assign rise = s_r.clk_s[1] & ~s_r.clk_s[2];
  assign fall = ~s_r.clk_s[1] & s_r.clk_s[2];
  assign act_edge = s_r.cfg[flash_cfg_pkg::CFG_EDGE_BIT] ? rise : fall;
  // Burst only once a configuration with the async bit clear has been loaded
  assign sync_mode = s_r.cfg_set & ~s_r.cfg[flash_cfg_pkg::CFG_ASYNC_BIT];
  // Write strobe: synced we_n rising while the chip is selected
  assign wr_stb = s_r.we_s[1] & ~s_r.we_s[2] & ~s_r.ce_s[1];
  assign avd_fall = ~s_r.avd_s[1] & s_r.avd_s[2] & ~s_r.ce_s[1];
  assign cmd = s_r.d2[7:0];
  assign bk = bank_of(s_r.a2);
  assign take = act_edge & ((s_r.bst == flash_cfg_pkg::B_RUN)
    | ((s_r.bst == flash_cfg_pkg::B_WAIT) & (s_r.wait_cnt <= 4'h1)));
  assign fifo_pop = take & fifo_out_valid;
  assign rdy_with_data = s_r.cfg[flash_cfg_pkg::CFG_RDY_BIT]
    | (s_r.cfg[flash_cfg_pkg::CFG_WAIT_HI:flash_cfg_pkg::CFG_WAIT_LO]
       == flash_cfg_pkg::WAIT_FASTEST);
  assign init_cycles = flash_cfg_pkg::WAIT_BASE
    + {1'b0, s_r.cfg[flash_cfg_pkg::CFG_WAIT_HI:flash_cfg_pkg::CFG_WAIT_LO]}
    + ((REDUCED_HS && (s_r.a2[5:1] == flash_cfg_pkg::SLOW_START_ADDR[5:1]))
       ? flash_cfg_pkg::SLOW_START_EXTRA : 4'h0);

  // The FIFO drops anything pushed in its flush cycle, so the first word of a
  // burst waits one cycle, or the address would step past it
  assign fill_ok = ~s_r.flush;

  // Address generator loads on a latched start, steps on each accepted array word
  assign ld = avd_fall;
  assign step = s_r.req & arr_valid & fifo_in_ready & ~s_r.as_read & fill_ok
    & (s_r.bst != flash_cfg_pkg::B_IDLE);
  // Autoselect bursts carry a single identifier word instead of array data
  assign fifo_in_valid = fill_ok
    & (s_r.as_read ? s_r.fetch_on : (s_r.req & arr_valid & s_r.fetch_on));
  assign fifo_in_data = s_r.as_read ? id_word(cur_addr[7:0]) : arr_data;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ce_s = {s_r.ce_s[0], ce_n};
    s_nxt.oe_s = {s_r.oe_s[0], oe_n};
    s_nxt.we_s = {s_r.we_s[1:0], we_n};
    s_nxt.avd_s = {s_r.avd_s[1:0], address_valid_strobe_n};
    s_nxt.clk_s = {s_r.clk_s[1:0], burst_clk};
    s_nxt.a1 = addr;
    s_nxt.a2 = s_r.a1;
    s_nxt.d1 = dq_i;
    s_nxt.d2 = s_r.d1;
    s_nxt.abort = 4'h0;
    s_nxt.flush = 1'b0;

    // Command decoding on the rising write strobe
    if (wr_stb)
    begin
      if (cmd == flash_cfg_pkg::CMD_RESET)
      begin
        // Address is don't care; an open sequence is dropped
        s_nxt.cyc = 2'h0;
        for (int i = 0; i < flash_cfg_pkg::NUM_BANKS; i++)
        begin
          // Suspended banks fall back to suspend-read since suspend is held outside
          s_nxt.autosel[i] = 1'b0;
          // Running operations ignore reset unless the time-limit flag is up
          s_nxt.abort[i] = bank_busy[i] & time_limit_exceeded_bit[i];
        end
      end
      else
      begin
        unique case (s_r.cyc)
          2'h0:
            s_nxt.cyc = (s_r.a2[11:0] == flash_cfg_pkg::UNLOCK1_ADDR
                         && cmd == flash_cfg_pkg::UNLOCK1_DATA) ? 2'h1 : 2'h0;
          2'h1:
            s_nxt.cyc = (s_r.a2[11:0] == flash_cfg_pkg::UNLOCK2_ADDR
                         && cmd == flash_cfg_pkg::UNLOCK2_DATA) ? 2'h2 : 2'h0;
          default:
          begin
            s_nxt.cyc = 2'h0;
            if (cmd == flash_cfg_pkg::CMD_CONFIG
                && s_r.a2[11:0] == flash_cfg_pkg::UNLOCK1_ADDR
                && bank_busy == 4'h0 && !lock_busy)
            begin
              s_nxt.cfg = s_r.a2[flash_cfg_pkg::CFG_CODE_LSB +: flash_cfg_pkg::CFG_W];
              s_nxt.cfg_set = 1'b1;
            end
            else if (cmd == flash_cfg_pkg::CMD_AUTOSEL && bank_busy == 4'h0)
              s_nxt.autosel[bk] = 1'b1;
          end
        endcase
      end
    end

    // Synchronous burst engine
    if (s_r.ce_s[1])
    begin
      // Chip deselect ends any burst and drops queued words
      s_nxt.bst = flash_cfg_pkg::B_IDLE;
      s_nxt.fetch_on = 1'b0;
      s_nxt.flush = 1'b1;
    end
    else if (avd_fall && sync_mode)
    begin
      s_nxt.bst = flash_cfg_pkg::B_WAIT;
      s_nxt.wait_cnt = init_cycles;
      s_nxt.as_read = s_r.autosel[bk];
      s_nxt.fetch_on = 1'b1;
      s_nxt.flush = 1'b1;
    end
    else
    begin
      if (s_r.as_read && fifo_in_valid && fifo_in_ready)
        s_nxt.fetch_on = 1'b0;
      if (s_r.bst == flash_cfg_pkg::B_WAIT && act_edge && s_r.wait_cnt > 4'h1)
        s_nxt.wait_cnt = s_r.wait_cnt - 4'h1;
      if (take)
        s_nxt.bst = flash_cfg_pkg::B_RUN;
    end

    // Array request: fetch while a burst runs, or follow the bus in async reads
    if (sync_mode)
      s_nxt.req = s_nxt.fetch_on & ~s_nxt.as_read;
    else
      s_nxt.req = ~s_r.ce_s[1] & ~s_r.oe_s[1];

    // Data and ready pins
    if (sync_mode)
    begin
      s_nxt.rdy_oe_n = s_r.ce_s[1];
      s_nxt.dq_oe_n = s_r.ce_s[1] | s_r.oe_s[1] | (s_r.bst != flash_cfg_pkg::B_RUN);
      if (fifo_pop)
        s_nxt.dq = fifo_out_data;
      if (s_r.bst == flash_cfg_pkg::B_IDLE)
        s_nxt.rdy = 1'b0;
      else if (rdy_with_data)
      begin
        if (take)
          s_nxt.rdy = fifo_out_valid;
      end
      else
        // Early ready: raised when the next active edge will have a word
        s_nxt.rdy = fifo_out_valid & ~fifo_pop
          & ((s_r.bst == flash_cfg_pkg::B_RUN) | (s_r.wait_cnt <= 4'h2));
    end
    else
    begin
      // Asynchronous read: ready line released, open-drain
      s_nxt.rdy = 1'b0;
      s_nxt.rdy_oe_n = 1'b1;
      s_nxt.dq_oe_n = s_r.ce_s[1] | s_r.oe_s[1];
      if (s_r.autosel[bank_of(cur_addr)])
        s_nxt.dq = id_word(cur_addr[7:0]);
      else if (arr_valid && s_r.req)
        s_nxt.dq = arr_data;
    end
  end

  always_ff @(posedge ref_clk)
    if (rst)
    begin
      s_r <= '0;
      // Pin samplers start at the idle level so no false edge follows reset
      s_r.ce_s <= 2'h3;
      s_r.oe_s <= 2'h3;
      s_r.we_s <= 3'h7;
      s_r.avd_s <= 3'h7;
      s_r.cfg <= flash_cfg_pkg::CFG_RESET;
      s_r.bst <= flash_cfg_pkg::B_IDLE;
      s_r.dq_oe_n <= 1'b1;
      s_r.rdy_oe_n <= 1'b1;
    end
    else
      s_r <= s_nxt;

  burst_addr_gen #(
    .ADDR_W(flash_cfg_pkg::ADDR_W)
  ) u_addr (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(ld),
    .start(s_r.a2),
    .step(step),
    .wrap_sel(s_r.cfg[flash_cfg_pkg::CFG_MODE_HI:flash_cfg_pkg::CFG_MODE_LO]),
    .cur_addr(cur_addr)
  );

  word_fifo #(
    .WIDTH(flash_cfg_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .flush(s_r.flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );
endmodule

// File: verif/flash_cmd_props.sv
`timescale 1ns/100ps
module flash_cmd_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] bank_busy,
  input wire logic lock_busy,
  input wire logic [3:0] time_limit_exceeded_bit,
  input wire logic [3:0] op_abort,
  input wire logic [3:0] bank_autosel,
  input wire logic [7:0] burst_configuration,
  input wire logic burst_config_set,
  input wire logic rdy_oe_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  reset_defaults_a:
    assert property ($fell(rst) |-> burst_configuration == flash_cfg_pkg::CFG_RESET
      && !burst_config_set && bank_autosel == 4'h0) else $error("bad state after reset");
  unset_no_burst_a:
    assert property (!burst_config_set |-> rdy_oe_n) else $error("ready driven before setup");
  set_flag_holds_a:
    assert property (burst_config_set |=> burst_config_set) else $error("setup flag dropped");
  busy_cfg_frozen_a:
    assert property ((bank_busy != 4'h0 || lock_busy) |=> $stable(burst_configuration))
      else $error("code changed while busy");
  async_rdy_released_a:
    assert property (burst_configuration[7] && $past(burst_configuration[7]) |-> rdy_oe_n)
      else $error("ready driven in async mode");
  abort_cause_a:
    assert property (op_abort != 4'h0 |->
      (op_abort & ~$past(bank_busy & time_limit_exceeded_bit)) == 4'h0)
      else $error("abort without time limit flag");
  abort_pulse_a:
    assert property (op_abort != 4'h0 |=> op_abort == 4'h0) else $error("abort longer than one");
  autosel_idle_a:
    assert property ((bank_autosel & ~$past(bank_autosel)) != 4'h0 |-> $past(bank_busy) == 4'h0)
      else $error("autoselect entered while busy");
  cover property (burst_config_set && !burst_configuration[7]);
  cover property (op_abort != 4'h0);
  cover property (bank_autosel != 4'h0);
endmodule
bind flash_burst_config_and_mode_commands flash_cmd_props props_u (
  .ref_clk(ref_clk),
  .rst(rst),
  .bank_busy(bank_busy),
  .lock_busy(lock_busy),
  .time_limit_exceeded_bit(time_limit_exceeded_bit),
  .op_abort(op_abort),
  .bank_autosel(bank_autosel),
  .burst_configuration(burst_configuration),
  .burst_config_set(burst_config_set),
  .rdy_oe_n(rdy_oe_n)
);

// File: verif/host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model (
  input wire logic ref_clk,
  input wire logic [15:0] dq_o,
  input wire logic rdy_o,
  input wire logic dq_oe_n,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic avs_n,
  output logic bclk,
  output logic [21:0] addr,
  output logic [15:0] dq_i
);
  initial
  begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    avs_n = 1'b1;
    bclk = 1'b0;
    addr = 22'h000000;
    dq_i = 16'h0000;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic let_go;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    avs_n = 1'b1;
    addr = ~addr;
    dq_i = ~dq_i;
  endtask
  // One write cycle, held well around the strobe rise
  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    ce_n = 1'b0;
    addr = a;
    dq_i = {8'h00, d};
    repeat (4) @(negedge ref_clk);
    we_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    we_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    let_go();
    repeat (4) @(negedge ref_clk);
  endtask
  // Sync burst, falling active edges: strobe, then eight burst clock periods,
  // sampling data and driven ready just before each rising edge
  task automatic burst(input logic [21:0] a, output logic [7:0][15:0] w,
    output logic [7:0] r);
    @(negedge ref_clk);
    ce_n = 1'b0;
    oe_n = 1'b0;
    avs_n = 1'b0;
    addr = a;
    repeat (2) @(negedge ref_clk);
    bclk = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      repeat (4) @(negedge ref_clk);
      bclk = 1'b0;
      repeat (4) @(negedge ref_clk);
      w[i] = dq_o;
      r[i] = rdy_o & ~dq_oe_n;
      bclk = 1'b1;
    end
    let_go();
    repeat (4) @(negedge ref_clk);
    // Park the clock low only once the chip is deselected
    bclk = 1'b0;
  endtask
  task automatic rd(input logic [21:0] a, output logic [15:0] v);
    @(negedge ref_clk);
    ce_n = 1'b0;
    oe_n = 1'b0;
    avs_n = 1'b0;
    addr = a;
    repeat (10) @(negedge ref_clk);
    v = dq_o;
    let_go();
    repeat (4) @(negedge ref_clk);
  endtask
endmodule

// File: verif/flash_burst_config_and_mode_commands_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end
module flash_burst_config_and_mode_commands_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce_n, oe_n, we_n, avs_n, bclk, dq_oe_n, rdy_o, rdy_oe_n, cfg_set, arr_req;
  logic [21:0] addr, arr_addr;
  logic [15:0] dq_i, dq_o, rv;
  logic [3:0] busy = 4'h0;
  logic [3:0] tle = 4'h0;
  logic [3:0] abort, autosel;
  logic [3:0] abort_seen = 4'h0;
  logic lock = 1'b0;
  logic [7:0] cfg;
  logic [7:0][15:0] bw;
  logic [7:0] br;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) abort_seen <= abort_seen | abort;
  host_bus_model host_u (.ref_clk(ref_clk), .dq_o(dq_o), .rdy_o(rdy_o),
    .dq_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .avs_n(avs_n), .bclk(bclk), .addr(addr), .dq_i(dq_i));
  flash_burst_config_and_mode_commands #(.ID_DEV1(16'h1234)) dut_u (.ref_clk(ref_clk),
    .rst(rst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .address_valid_strobe_n(avs_n),
    .burst_clk(bclk), .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
    .rdy_o(rdy_o), .rdy_oe_n(rdy_oe_n), .bank_busy(busy), .lock_busy(lock),
    .time_limit_exceeded_bit(tle), .op_abort(abort), .bank_autosel(autosel),
    .burst_configuration(cfg), .burst_config_set(cfg_set), .arr_addr(arr_addr),
    .arr_req(arr_req), .arr_data(arr_addr[15:0] ^ 16'h0f0f), .arr_valid(arr_req));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic cmd3(input logic [21:0] a, input logic [7:0] d);
    host_u.wr(22'h000555, 8'haa);
    host_u.wr(22'h0002aa, 8'h55);
    host_u.wr(a, d);
  endtask
  task automatic t_defaults;
    `CHK("async", 1'b1, cfg[7])
    `CHK("wait", 3'h5, cfg[2:0])
    `CHK("wrap", flash_cfg_pkg::MODE_CONT, cfg[4:3])
    `CHK("edge", 1'b1, cfg[5])
    `CHK("ready", 1'b1, cfg[6])
    `CHK("set", 1'b0, cfg_set)
    `CHK("rdy oe", 1'b1, rdy_oe_n)
    `CHK("dq oe", 1'b1, dq_oe_n)
    `CHK("rdy", 1'b0, rdy_o)
    `CHK("arr req", 1'b0, arr_req)
    `CHK("arr addr", 22'h000000, arr_addr)
  endtask
  task automatic t_config;
    busy = 4'h2;
    cmd3(22'h04a555, 8'hc0);
    `CHK("busy cfg", 8'he5, cfg)
    busy = 4'h0;
    lock = 1'b1;
    cmd3(22'h04a555, 8'hc0);
    `CHK("lock cfg", 8'he5, cfg)
    lock = 1'b0;
    host_u.wr(22'h000556, 8'haa);
    host_u.wr(22'h0002aa, 8'h55);
    host_u.wr(22'h04a555, 8'hc0);
    `CHK("bad unlock", 8'he5, cfg)
    // Sync, ready with data, falling edge, 8-word wrap, wait 010
    cmd3(22'h04a555, 8'hc0);
    `CHK("code", 8'h4a, cfg)
    `CHK("set", 1'b1, cfg_set)
  endtask
  task automatic t_burst;
    // Wait 010 on fast handshaking: the fourth falling edge brings the first word
    host_u.burst(22'h000005, bw, br);
    `CHK("rdy timing", 8'hf8, br)
    `CHK("wrap8 words", 80'h0f0e_0f0f_0f08_0f09_0f0a, bw[7:3])
    // Start at 3Eh costs two more edges and stays inside its aligned block
    host_u.burst(22'h00003e, bw, br);
    `CHK("slow rdy", 8'he0, br)
    `CHK("block words", 48'h0f37_0f30_0f31, bw[7:5])
    // Back to async with wait 101
    cmd3(22'h0e5555, 8'hc0);
    `CHK("async code", 8'he5, cfg)
  endtask
  task automatic t_abort;
    busy = 4'h6;
    tle = 4'h4;
    abort_seen = 4'h0;
    host_u.wr(22'h3abcde, 8'hf0);
    `CHK("abort", 4'h4, abort_seen)
    busy = 4'h0;
    tle = 4'h0;
  endtask
  task automatic t_autosel;
    busy = 4'h1;
    cmd3(flash_cfg_pkg::BANK_C_START | 22'h000555, 8'h90);
    `CHK("busy entry", 4'h0, autosel)
    busy = 4'h0;
    host_u.wr(22'h000555, 8'haa);
    host_u.wr(22'h012345, 8'hf0);
    host_u.wr(flash_cfg_pkg::BANK_C_START | 22'h000555, 8'h90);
    `CHK("aborted", 4'h0, autosel)
    cmd3(flash_cfg_pkg::BANK_C_START | 22'h000555, 8'h90);
    `CHK("entry", 4'h4, autosel)
    repeat (2)
    begin
      host_u.rd(flash_cfg_pkg::BANK_C_START | 22'h000001, rv);
      `CHK("id", 16'h1234, rv)
    end
    host_u.rd(22'h000010, rv);
    `CHK("array", 16'h0f1f, rv)
    host_u.wr(22'h000000, 8'hf0);
    `CHK("exit", 4'h0, autosel)
  endtask
  initial
  begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (5) @(negedge ref_clk);
    t_defaults();
    t_config();
    t_burst();
    t_abort();
    t_autosel();
    report_and_stop();
  end
endmodule
